// [core/acw_ctl0.sv]
// converter control word zero: register, mode decode and pair sequencing
`timescale 1ns/1ps
`default_nettype none
module acw_ctl0
   import acw_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1,
   parameter int ADDR_W = 12
) (
   // clock, reset and freeze
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // converter timing and triggers
   input wire logic convTick,
   input wire logic firstStart,
   input wire logic routineConvDone,
   // conversion results and event flags
   input wire logic resultValid,
   input wire logic [4:0] resultChannel,
   input wire logic convEndFlag,
   input wire logic wcmp0_event_flag,
   input wire logic wcmp1_event_flag,
   // decoded control fields
   output logic wcmp1_irq_en,
   output logic routine_wcmp0_en,
   output logic [3:0] pair_sync_select,
   output logic [2:0] disc_group_count,
   output logic routine_disc_en,
   output logic wcmp0_single_channel,
   output logic scan_en,
   output logic wcmp0_irq_en,
   output logic conv_end_irq_en,
   output logic [4:0] wcmp0_channel_select,
   // derived behaviour
   output acw_sync_t syncMode,
   output logic [3:0] groupSize,
   output logic secondStart,
   output logic groupDone,
   output logic wcmp0Check,
   output logic irqReq
);
   // register and bus signals
   logic [31:0] ctl0_q, ctl0_d;
   logic [31:0] wrMerged;
   logic [31:0] rdData;
   logic [31:0] statWord;
   logic hitCtl, hitStat, wrStb;

   // sequencing state
   acw_sync_t applied_q, applied_d;
   logic seqErr_q, seqErr_d;
   logic overrun_q, overrun_d;
   logic followStart;
   logic [3:0] followDelay;
   logic followFire;
   logic followBusy;

   // group counter and checker state
   logic [2:0] groupCnt_q, groupCnt_d;
   logic groupDone_q, groupDone_d;
   logic wcmp0Check_q, wcmp0Check_d;
   logic irq_q, irq_d;

   // decode helpers
   acw_sync_t fieldMode;
   logic [3:0] newSync;
   logic rsvdSync;
   logic rsvdChan;
   logic chanMatch;

   // bus front end
   acw_apb_port #(
      .ADDR_W(ADDR_W)
   ) u_port (
      .sys_clk(sys_clk),
      .srst(srst),
      .clkEn(clkEn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .rdData(rdData),
      .hitCtl(hitCtl),
      .hitStat(hitStat),
      .wrStb(wrStb)
   );

   // field views straight off the control flop
   assign wcmp1_irq_en = ctl0_q[POS_WCMP1_IE];
   assign routine_wcmp0_en = ctl0_q[POS_RWCMP0_EN];
   assign pair_sync_select = ctl0_q[POS_SYNC +: 4];
   assign disc_group_count = ctl0_q[POS_DISC_CNT +: 3];
   assign routine_disc_en = ctl0_q[POS_DISC_EN];
   assign wcmp0_single_channel = ctl0_q[POS_SINGLE];
   assign scan_en = ctl0_q[POS_SCAN];
   assign wcmp0_irq_en = ctl0_q[POS_WCMP0_IE];
   assign conv_end_irq_en = ctl0_q[POS_EOC_IE];
   assign wcmp0_channel_select = ctl0_q[POS_CHSEL +: 5];

   // group size is count plus one, widened so that count 7 gives 8;
   // the group counter below compares against the raw count instead
   assign groupSize = {1'b0, disc_group_count} + 4'h1;

   // field decode; reserved codes read back but act as free mode
   assign fieldMode = acw_decode_sync(pair_sync_select);
   assign rsvdSync = ~acw_sync_legal(pair_sync_select);
   assign rsvdChan = wcmp0_channel_select > CHSEL_MAX;

   // write merge: byte lanes honour pstrb, reserved bits forced to zero
   always_comb begin
      wrMerged = ctl0_q;
      for (int i = 0; i < 4; i++) begin
         if (pstrb[i]) begin
            wrMerged[8*i +: 8] = pwdata[8*i +: 8];
         end
      end
      wrMerged = wrMerged & CTL0_WMASK;
      newSync = wrMerged[POS_SYNC +: 4];
      ctl0_d = ctl0_q;
      if (wrStb & hitCtl) begin
         ctl0_d = wrMerged;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctl0_q <= CTL0_RESET;
      end else if (clkEn) begin
         ctl0_q <= ctl0_d;
      end
   end

   // the mode that the pair really runs in; only the first instance has one.
   // a change waits while a follow-up start is pending so that a half-done
   // pair start is never cut short by a new mode
   always_comb begin
      applied_d = applied_q;
      if (!FIRST_INSTANCE) begin
         applied_d = SYNC_FREE;
      end else if (!followBusy) begin
         applied_d = fieldMode;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         applied_q <= SYNC_FREE;
      end else if (clkEn) begin
         applied_q <= applied_d;
      end
   end

   assign syncMode = applied_q;

   // sticky error flags: a write that moves the sync field from one nonzero code to another
   // without passing code 0000, and a trigger while a follow-up is pending.
   // writing one to the status bit clears it, but a new event wins
   always_comb begin
      seqErr_d = seqErr_q;
      overrun_d = overrun_q;
      if (wrStb & hitStat & pwdata[POS_ST_SEQ_ERR] & pstrb[0]) begin
         seqErr_d = 1'b0;
      end
      if (wrStb & hitStat & pwdata[POS_ST_OVERRUN] & pstrb[0]) begin
         overrun_d = 1'b0;
      end
      if (wrStb & hitCtl & (pair_sync_select != SYNC_CODE_FREE) &
          (newSync != SYNC_CODE_FREE) & (newSync != pair_sync_select)) begin
         seqErr_d = 1'b1;
      end
      if (firstStart & followBusy) begin
         overrun_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seqErr_q <= 1'b0;
         overrun_q <= 1'b0;
      end else if (clkEn) begin
         seqErr_q <= seqErr_d;
         overrun_q <= overrun_d;
      end
   end

   // follow-up modes start the delay on the first converter's start.
   // the delay counts converter ticks, not bus clocks, so the follow-up
   // distance holds while ticks come no faster than one per bus clock; a trigger while a
   // count is pending restarts it rather than queueing a second start
   always_comb begin
      followStart = 1'b0;
      followDelay = FAST_DELAY;
      unique case (applied_q)
         SYNC_FAST: begin
            followStart = firstStart & clkEn;
            followDelay = FAST_DELAY;
         end
         SYNC_SLOW: begin
            followStart = firstStart & clkEn;
            followDelay = SLOW_DELAY;
         end
         SYNC_FREE,
         SYNC_PARALLEL: begin
            followStart = 1'b0;
         end
      endcase
   end

   acw_follow_delay #(
      .CNT_W(4)
   ) u_delay (
      .sys_clk(sys_clk),
      .srst(srst),
      .clkEn(clkEn),
      .convTick(convTick),
      .start(followStart),
      .delay(followDelay),
      .fire(followFire),
      .busy(followBusy)
   );

   // parallel starts the second converter in the same cycle as the first;
   // no flop here, so the pair sees its trigger on the very same edge
   always_comb begin
      secondStart = followFire;
      if ((applied_q == SYNC_PARALLEL) & firstStart & clkEn) begin
         secondStart = 1'b1;
      end
   end

   // discontinuous groups: count routine conversions since the group began
   always_comb begin
      groupCnt_d = groupCnt_q;
      groupDone_d = 1'b0;
      if (!routine_disc_en) begin
         groupCnt_d = 3'h0;
      end else if (routineConvDone) begin
         if (groupCnt_q >= disc_group_count) begin
            groupCnt_d = 3'h0;
            groupDone_d = 1'b1;
         end else begin
            groupCnt_d = groupCnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         groupCnt_q <= 3'h0;
         groupDone_q <= 1'b0;
      end else if (clkEn) begin
         groupCnt_q <= groupCnt_d;
         groupDone_q <= groupDone_d;
      end
   end

   assign groupDone = groupDone_q;

   // window comparator 0 check strobe for each routine result.
   // single-channel limiting only applies in scan; a reserved channel
   // code never matches because the match is masked by the reserved-channel flag rsvdChan
   always_comb begin
      chanMatch = (resultChannel == wcmp0_channel_select) & ~rsvdChan;
      wcmp0Check_d = 1'b0;
      if (resultValid & routine_wcmp0_en) begin
         if (scan_en & wcmp0_single_channel) begin
            wcmp0Check_d = chanMatch;
         end else begin
            wcmp0Check_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wcmp0Check_q <= 1'b0;
      end else if (clkEn) begin
         wcmp0Check_q <= wcmp0Check_d;
      end
   end

   assign wcmp0Check = wcmp0Check_q;

   // interrupt request: each flag gated by its own enable, registered.
   // in a synchronised pair each instance raises only on its own flags,
   // so the first converter answers for its own conversion end
   always_comb begin
      irq_d = 1'b0;
      if (convEndFlag & conv_end_irq_en) begin
         irq_d = 1'b1;
      end
      if (wcmp0_event_flag & wcmp0_irq_en) begin
         irq_d = 1'b1;
      end
      if (wcmp1_event_flag & wcmp1_irq_en) begin
         irq_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else if (clkEn) begin
         irq_q <= irq_d;
      end
   end

   assign irqReq = irq_q;

   // status word and read mux; unused bits read zero
   always_comb begin
      statWord = 32'h00000000;
      statWord[POS_ST_MODE +: 2] = 2'(applied_q);
      statWord[POS_ST_RSVD_SYNC] = rsvdSync;
      statWord[POS_ST_SEQ_ERR] = seqErr_q;
      statWord[POS_ST_RSVD_CH] = rsvdChan;
      statWord[POS_ST_BUSY] = followBusy;
      statWord[POS_ST_IRQ] = irq_q;
      statWord[POS_ST_OVERRUN] = overrun_q;
      rdData = 32'h00000000;
      if (hitCtl) begin
         rdData = ctl0_q;
      end else if (hitStat) begin
         rdData = statWord;
      end
   end
endmodule
`default_nettype wire

// [core/acw_pkg.sv]
// constants, types and decode helpers for converter control word zero
`default_nettype none
// Overview of operation
// - bit 30 gates the window-comparator-1 interrupt request
// - bit 23 enables window-comparator-0 checks on routine conversion results
// - sync field 19:16: 0000 free, 0110 parallel, 0111 fast, 1000 slow
// - sync field acts only in the first converter instance
// - discontinuous group size per trigger is count field 15:13 plus one
// - bit 11 splits the routine sequence into discontinuous groups
// - in scan, bit 9 limits window-comparator-0 checks to one channel
// - bit 8 enables scan through the configured channel sequence
// - bit 6 gates the window-comparator-0 interrupt request
// - bit 5 gates the end-of-conversion interrupt request
// - bits 4:0 pick the checked channel, 0 to 17, higher codes reserved
// - fast follow-up starts the second converter 7 converter clocks later
// - slow follow-up starts the second converter 14 converter clocks later
// - parallel mode starts both converters together on the first trigger
// - in synchronised modes the first converter raises its own end interrupt
package acw_pkg;
   // register map
   localparam logic [11:0] OFS_CTL0 = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h040;
   localparam logic [31:0] CTL0_RESET = 32'h00000000;
   localparam logic [31:0] CTL0_WMASK = 32'h408feb7f;
   // control word field positions
   localparam int POS_WCMP1_IE = 30;
   localparam int POS_RWCMP0_EN = 23;
   localparam int POS_SYNC = 16;
   localparam int POS_DISC_CNT = 13;
   localparam int POS_DISC_EN = 11;
   localparam int POS_SINGLE = 9;
   localparam int POS_SCAN = 8;
   localparam int POS_WCMP0_IE = 6;
   localparam int POS_EOC_IE = 5;
   localparam int POS_CHSEL = 0;
   // sync codes and channel range
   localparam logic [3:0] SYNC_CODE_FREE = 4'h0;
   localparam logic [3:0] SYNC_CODE_PAR = 4'h6;
   localparam logic [3:0] SYNC_CODE_FAST = 4'h7;
   localparam logic [3:0] SYNC_CODE_SLOW = 4'h8;
   localparam logic [4:0] CHSEL_MAX = 5'h11;
   // follow-up delays in converter clock cycles
   localparam logic [3:0] FAST_DELAY = 4'h7;
   localparam logic [3:0] SLOW_DELAY = 4'he;
   // status word bit positions
   localparam int POS_ST_MODE = 0;
   localparam int POS_ST_RSVD_SYNC = 2;
   localparam int POS_ST_SEQ_ERR = 3;
   localparam int POS_ST_RSVD_CH = 4;
   localparam int POS_ST_BUSY = 5;
   localparam int POS_ST_IRQ = 6;
   localparam int POS_ST_OVERRUN = 7;

   typedef enum logic [1:0] {
      SYNC_FREE,
      SYNC_PARALLEL,
      SYNC_FAST,
      SYNC_SLOW
   } acw_sync_t;

   // reserved codes fall back to free mode
   function automatic acw_sync_t acw_decode_sync(input logic [3:0] code);
      acw_sync_t m;
      m = SYNC_FREE;
      if (code == SYNC_CODE_PAR) m = SYNC_PARALLEL;
      else if (code == SYNC_CODE_FAST) m = SYNC_FAST;
      else if (code == SYNC_CODE_SLOW) m = SYNC_SLOW;
      return m;
   endfunction

   function automatic logic acw_sync_legal(input logic [3:0] code);
      return (code == SYNC_CODE_FREE) || (code == SYNC_CODE_PAR) ||
         (code == SYNC_CODE_FAST) || (code == SYNC_CODE_SLOW);
   endfunction
endpackage
`default_nettype wire

// [core/acw_apb_port.sv]
// apb slave front end: address decode, strobes and registered read data
`timescale 1ns/1ps
`default_nettype none
module acw_apb_port
   import acw_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock, reset and freeze
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // register side
   input wire logic [31:0] rdData,
   output logic hitCtl,
   output logic hitStat,
   output logic wrStb
);
   logic [31:0] prdata_q, prdata_d;
   logic hitAny;

   // read data is captured in the setup cycle so the answer comes from a flop
   always_comb begin
      hitCtl = paddr == ADDR_W'(OFS_CTL0);
      hitStat = paddr == ADDR_W'(OFS_STAT);
      hitAny = hitCtl | hitStat;
      pready = clkEn; // no wait states unless frozen
      pslverr = psel & penable & clkEn & ~hitAny;
      wrStb = psel & penable & clkEn & pwrite & hitAny;
      prdata_d = prdata_q;
      if (psel & ~penable & ~pwrite) begin
         prdata_d = hitAny ? rdData : 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata_q <= 32'h00000000;
      end else if (clkEn) begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
endmodule
`default_nettype wire

// [core/acw_follow_delay.sv]
// counts converter clock ticks from the first start to the second start
`timescale 1ns/1ps
`default_nettype none
module acw_follow_delay
   import acw_pkg::*;
#(
   parameter int CNT_W = 4
) (
   // clock, reset and freeze
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // timing
   input wire logic convTick,
   input wire logic start,
   input wire logic [CNT_W-1:0] delay,
   // result
   output logic fire,
   output logic busy
);
   typedef enum logic {ST_IDLE, ST_WAIT} acw_fd_state_t;
   acw_fd_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic fire_q, fire_d;

   // a new start restarts the count; the earlier follow-up is dropped
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      fire_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (start) begin
               cnt_d = delay;
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (start) begin
               cnt_d = delay;
            end else if (convTick) begin
               cnt_d = cnt_q - CNT_W'(1);
               if (cnt_q <= CNT_W'(1)) begin
                  fire_d = 1'b1;
                  state_d = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         fire_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         fire_q <= fire_d;
      end
   end

   assign fire = fire_q & clkEn;
   assign busy = state_q == ST_WAIT;
endmodule
`default_nettype wire

// [sim/acw_ctl0_chk.sv]
// assertion checker for converter control word zero
`timescale 1ns/1ps
`default_nettype none
module acw_ctl0_chk
   import acw_pkg::*;
(
   // clock and control
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // converter side inputs
   input wire logic convTick,
   input wire logic firstStart,
   input wire logic resultValid,
   input wire logic [4:0] resultChannel,
   input wire logic convEndFlag,
   input wire logic wcmp0_event_flag,
   input wire logic wcmp1_event_flag,
   // decoded fields
   input wire logic wcmp1_irq_en,
   input wire logic routine_wcmp0_en,
   input wire logic [2:0] disc_group_count,
   input wire logic wcmp0_single_channel,
   input wire logic scan_en,
   input wire logic wcmp0_irq_en,
   input wire logic conv_end_irq_en,
   input wire logic [4:0] wcmp0_channel_select,
   // derived outputs
   input wire acw_sync_t syncMode,
   input wire logic [3:0] groupSize,
   input wire logic secondStart,
   input wire logic wcmp0Check,
   input wire logic irqReq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   // causes; a fresh start must not count as a follow-up tick
   logic tickOnly;
   logic irqCause;
   logic chkCause;
   assign tickOnly = convTick && clkEn && !firstStart;
   assign irqCause = (wcmp1_event_flag && wcmp1_irq_en) ||
      (wcmp0_event_flag && wcmp0_irq_en) || (convEndFlag && conv_end_irq_en);
   assign chkCause = routine_wcmp0_en && (!(scan_en && wcmp0_single_channel)
      || (resultChannel == wcmp0_channel_select &&
      wcmp0_channel_select <= CHSEL_MAX));

   AST_GROUP_SIZE: assert property (
      groupSize == {1'b0, disc_group_count} + 4'h1)
      else $error("group size is not count plus one");
   AST_IRQ_OR: assert property (
      clkEn |=> irqReq == $past(irqCause))
      else $error("interrupt request does not follow flags and enables");
   AST_CHECK_SEL: assert property (
      resultValid && clkEn |=> wcmp0Check == $past(chkCause))
      else $error("window check does not follow channel selection");
   AST_CHECK_IDLE: assert property (
      !resultValid && clkEn |=> !wcmp0Check)
      else $error("window check without a result");
   AST_PARALLEL: assert property (
      syncMode == SYNC_PARALLEL && firstStart |-> secondStart)
      else $error("parallel start not simultaneous");
   AST_FAST: assert property (
      firstStart && syncMode == SYNC_FAST ##1 tickOnly [*7] |=> secondStart)
      else $error("fast follow-up start missing");
   AST_SLOW: assert property (
      firstStart && syncMode == SYNC_SLOW ##1 tickOnly [*7] ##1
      tickOnly [*7] |=> secondStart)
      else $error("slow follow-up start missing");
   AST_FREE_QUIET: assert property (
      syncMode == SYNC_FREE && $past(syncMode) == SYNC_FREE |-> !secondStart)
      else $error("second start in free mode");

   // main scenarios reached
   cover property (syncMode == SYNC_SLOW && secondStart);
   cover property (irqReq);
   cover property (wcmp0Check && scan_en);
endmodule
`default_nettype wire

// [sim/test_adc_control_word_zero.sv]
// self-checking bench for converter control word zero
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_word_zero
   import acw_pkg::*;
;
   logic sys_clk = 1'b0, srst = 1'b1, clkEn = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic convTick = 1'b0, firstStart = 1'b0, routineConvDone = 1'b0;
   logic resultValid = 1'b0, convEndFlag = 1'b0;
   logic [4:0] resultChannel = 5'h00;
   logic wcmp0_event_flag = 1'b0, wcmp1_event_flag = 1'b0;
   logic pready, pslverr, wcmp1_irq_en, routine_wcmp0_en, routine_disc_en;
   logic wcmp0_single_channel, scan_en, wcmp0_irq_en, conv_end_irq_en;
   logic secondStart, groupDone, wcmp0Check, irqReq, er;
   logic [31:0] prdata, rd, seenWord;
   logic [3:0] pair_sync_select, groupSize;
   logic [2:0] disc_group_count;
   logic [4:0] wcmp0_channel_select;
   acw_sync_t syncMode, syncMode2;
   int err_total = 0, num_checks = 0, cycles = 0;

   acw_ctl0 dut (.sys_clk, .srst, .clkEn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .pslverr, .prdata, .convTick, .firstStart,
      .routineConvDone, .resultValid, .resultChannel, .convEndFlag,
      .wcmp0_event_flag, .wcmp1_event_flag, .wcmp1_irq_en, .routine_wcmp0_en,
      .pair_sync_select, .disc_group_count, .routine_disc_en,
      .wcmp0_single_channel, .scan_en, .wcmp0_irq_en, .conv_end_irq_en,
      .wcmp0_channel_select, .syncMode, .groupSize, .secondStart, .groupDone,
      .wcmp0Check, .irqReq);

   // second converter of a pair: its sync field must stay without effect
   acw_ctl0 #(.FIRST_INSTANCE(1'b0)) dut2 (.sys_clk, .srst, .clkEn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready(), .pslverr(),
      .prdata(), .convTick, .firstStart, .routineConvDone, .resultValid,
      .resultChannel, .convEndFlag, .wcmp0_event_flag, .wcmp1_event_flag,
      .wcmp1_irq_en(), .routine_wcmp0_en(), .pair_sync_select(),
      .disc_group_count(), .routine_disc_en(), .wcmp0_single_channel(),
      .scan_en(), .wcmp0_irq_en(), .conv_end_irq_en(),
      .wcmp0_channel_select(), .syncMode(syncMode2), .groupSize(),
      .secondStart(), .groupDone(), .wcmp0Check(), .irqReq());

   // decoded fields put back at their word positions
   assign seenWord = {1'b0, wcmp1_irq_en, 6'h00, routine_wcmp0_en, 3'h0,
      pair_sync_select, disc_group_count, 1'b0, routine_disc_en, 1'b0,
      wcmp0_single_channel, scan_en, 1'b0, wcmp0_irq_en, conv_end_irq_en,
      wcmp0_channel_select};

   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; an idle edge after it samples psel low before the next transfer starts
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic testRegs();
      logic [31:0] v [11] = '{32'h40000000, 32'h00800000, 32'h00060000,
         32'h0000a000, 32'h00000800, 32'h00000200, 32'h00000100,
         32'h00000040, 32'h00000020, 32'h00000011, 32'hffffffff};
      apb(1'b0, OFS_CTL0, 32'h00000000);
      chk("ctl0 reset", 32'h00000000, rd);
      foreach (v[i]) begin
         apb(1'b1, OFS_CTL0, v[i]);
         chk("fields", v[i] & 32'h408feb7f, seenWord);
         chk("group size", 32'(v[i][15:13]) + 32'h1, 32'(groupSize));
         apb(1'b0, OFS_CTL0, 32'h00000000);
         chk("readback", v[i] & 32'h408feb7f, rd);
      end
      // unmapped place: refused, control word untouched
      apb(1'b1, 12'h008, 32'h00000000);
      chk("unmapped error", 32'h1, 32'(er));
      apb(1'b0, OFS_CTL0, 32'h00000000);
      chk("after unmapped", 32'h408feb7f, rd);
      apb(1'b1, OFS_CTL0, 32'h00000000);
      $display("registers done");
   endtask

   task automatic testIrq();
      for (int i = 0; i < 64; i++) begin
         apb(1'b1, OFS_CTL0, 32'h00060000 | (32'(i[5]) << 30) |
            (32'(i[4]) << 6) | (32'(i[3]) << 5));
         {wcmp1_event_flag, wcmp0_event_flag, convEndFlag} <= i[2:0];
         repeat (2) @(posedge sys_clk);
         chk("irq", 32'((i[5] & i[2]) | (i[4] & i[1]) | (i[3] & i[0])),
            32'(irqReq));
      end
      {wcmp1_event_flag, wcmp0_event_flag, convEndFlag} <= 3'h0;
      apb(1'b1, OFS_CTL0, 32'h00000000);
      $display("interrupts done");
   endtask

   // latency counted in edges from the start edge; 30 means none came
   task automatic testSync();
      logic [3:0] code [4] = '{SYNC_CODE_PAR, SYNC_CODE_FAST,
         SYNC_CODE_SLOW, 4'h3};
      acw_sync_t mode [4] = '{SYNC_PARALLEL, SYNC_FAST, SYNC_SLOW, SYNC_FREE};
      int lat [4] = '{0, 8, 15, 30};
      int n;
      convTick <= 1'b1;
      foreach (code[i]) begin
         apb(1'b1, OFS_CTL0, 32'(code[i]) << 16);
         repeat (2) @(posedge sys_clk);
         chk("sync mode", 32'(mode[i]), 32'(syncMode));
         chk("second unit mode", 32'(SYNC_FREE), 32'(syncMode2));
         firstStart <= 1'b1;
         n = 0;
         @(posedge sys_clk);
         while (secondStart !== 1'b1 && n < 30) begin
            firstStart <= 1'b0;
            n++;
            @(posedge sys_clk);
         end
         firstStart <= 1'b0;
         chk("follow latency", 32'(lat[i]), 32'(n));
         apb(1'b1, OFS_CTL0, 32'h00000000);
         repeat (2) @(posedge sys_clk);
         chk("free mode", 32'(SYNC_FREE), 32'(syncMode));
      end
      convTick <= 1'b0;
      $display("sync done");
   endtask

   task automatic testCheck();
      logic [31:0] w [6] = '{32'h00000003, 32'h00800200, 32'h00800311,
         32'h00800311, 32'h00800100, 32'h00800312};
      logic [4:0] ch [6] = '{5'h03, 5'h03, 5'h11, 5'h10, 5'h05, 5'h12};
      logic exp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      foreach (w[i]) begin
         apb(1'b1, OFS_CTL0, w[i]);
         resultChannel <= ch[i];
         resultValid <= 1'b1;
         @(posedge sys_clk);
         resultValid <= 1'b0;
         @(posedge sys_clk);
         chk("range check", 32'(exp[i]), 32'(wcmp0Check));
      end
      $display("window check done");
   endtask

   task automatic testDisc();
      logic [31:0] w [2] = '{32'h00004800, 32'h00004000};
      int exp [2] = '{2, 0};
      int n;
      foreach (w[i]) begin
         apb(1'b1, OFS_CTL0, w[i]);
         n = 0;
         repeat (6) begin
            routineConvDone <= 1'b1;
            @(posedge sys_clk);
            routineConvDone <= 1'b0;
            @(posedge sys_clk);
            if (groupDone === 1'b1) n++;
         end
         chk("group done", 32'(exp[i]), 32'(n));
      end
      $display("discontinuous done");
   endtask

   // freeze: enable low holds the bus off and every flop still
   task automatic testFreeze();
      apb(1'b1, OFS_CTL0, 32'h40000000);
      clkEn <= 1'b0;
      wcmp1_event_flag <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("pready frozen", 32'h0, 32'(pready));
      chk("irq frozen", 32'h0, 32'(irqReq));
      clkEn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("irq after freeze", 32'h1, 32'(irqReq));
      wcmp1_event_flag <= 1'b0;
      apb(1'b1, OFS_CTL0, 32'h00000000);
      $display("freeze done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // reset for three cycles, then the tests in turn
   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      testRegs();
      testIrq();
      testSync();
      testCheck();
      testDisc();
      testFreeze();
      complete_run();
   end
endmodule

bind acw_ctl0 acw_ctl0_chk u_chk (.sys_clk, .srst, .clkEn, .convTick,
   .firstStart, .resultValid, .resultChannel, .convEndFlag, .wcmp0_event_flag,
   .wcmp1_event_flag, .wcmp1_irq_en, .routine_wcmp0_en, .disc_group_count,
   .wcmp0_single_channel, .scan_en, .wcmp0_irq_en, .conv_end_irq_en,
   .wcmp0_channel_select, .syncMode, .groupSize, .secondStart, .wcmp0Check,
   .irqReq);
`default_nettype wire
